// ---- hdl/core_flags_pc_stack.sv ----
`timescale 1ns/1ps
`default_nettype none

module core_flags_pc_stack
(
  // Clock and power-on reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // Other reset causes, one-cycle pulses from the reset controller
  input  wire logic        soft_reset_in,
  input  wire logic        brownout_reset_in,
  // AXI4-Lite write address and data
  input  wire logic [core_flags_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [core_flags_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Peripheral events, same clock
  input  wire logic        eeprom_write_done_in,
  input  wire logic        comparator_change_in,
  input  wire logic        serial_rx_full_in,
  input  wire logic        serial_tx_empty_in,
  input  wire logic [1:0]  ccp_mode_in,
  input  wire logic        ccp_capture_in,
  input  wire logic        ccp_compare_match_in,
  input  wire logic        period_match_in,
  input  wire logic        wide_timer_overflow_in,
  // Oscillator configuration
  input  wire logic        external_resistor_osc_in,
  input  wire logic        brownout_enable_config_in,
  // Instruction decoder strobes
  input  wire logic        instr_step_in,
  input  wire logic        jump_in,
  input  wire logic        call_in,
  input  wire logic        return_in,
  input  wire logic        vector_in,
  input  wire logic [10:0] target_in,
  // Core outputs
  output logic [12:0]      pc_out,
  output logic [4:0]       pc_high_latch_out,
  output logic             peripheral_irq_out,
  output logic             osc_fast_internal_out,
  output logic             osc_resistor_rate_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]        flags;
    logic [7:0]        enables;
    logic              osc_speed;
    logic              power_on;
    logic              brownout;
    logic [4:0]        latch;
    logic [12:0]       pc;
    logic [7:0][12:0]  stack;
    logic [2:0]        sp;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       wr_take;
  logic       rd_take;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic       wr_aligned;
  logic       rd_aligned;
  logic       wr_lane0;
  logic [7:0] wbyte;
  logic [7:0] flag_events;
  logic [7:0] flags_view;
  logic [7:0] cause_view;
  logic       any_reset;
  logic       pc_low_write;

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // Address and data taken together; keeps one write in flight
  assign wr_take           = s_axi_awvalid_in && s_axi_wvalid_in && !st_r.bvalid;
  assign rd_take           = s_axi_arvalid_in && !st_r.rvalid;
  assign s_axi_awready_out = s_axi_wvalid_in && !st_r.bvalid;
  assign s_axi_wready_out  = s_axi_awvalid_in && !st_r.bvalid;
  assign s_axi_arready_out = !st_r.rvalid;
  assign s_axi_bvalid_out  = st_r.bvalid;
  assign s_axi_bresp_out   = st_r.bresp;
  assign s_axi_rvalid_out  = st_r.rvalid;
  assign s_axi_rresp_out   = st_r.rresp;
  assign s_axi_rdata_out   = st_r.rdata;

  // Address decode; registers sit in byte lane 0
  assign wr_idx     = s_axi_awaddr_in[core_flags_pkg::ADDR_W-1:2];
  assign rd_idx     = s_axi_araddr_in[core_flags_pkg::ADDR_W-1:2];
  assign wr_aligned = (s_axi_awaddr_in[1:0] == 2'b00);
  assign rd_aligned = (s_axi_araddr_in[1:0] == 2'b00);
  assign wr_lane0   = wr_take && wr_aligned && s_axi_wstrb_in[0];
  assign wbyte      = s_axi_wdata_in[7:0];

  // ****************************************************************
  // Event sources and read views
  // ****************************************************************
  // Events feed flags with no enable in the path
  always_comb
  begin
    flag_events = 8'h00;
    flag_events[core_flags_pkg::BIT_EEPROM_DONE]  = eeprom_write_done_in;
    flag_events[core_flags_pkg::BIT_COMPARATOR]   = comparator_change_in;
    flag_events[core_flags_pkg::BIT_CAPT_COMP]    =
      (ccp_mode_in == core_flags_pkg::CCP_CAPTURE && ccp_capture_in) ||
      (ccp_mode_in == core_flags_pkg::CCP_COMPARE && ccp_compare_match_in);
    flag_events[core_flags_pkg::BIT_PERIOD_MATCH] = period_match_in;
    flag_events[core_flags_pkg::BIT_WIDE_OVF]     = wide_timer_overflow_in;
  end

  // Serial bits mirror the buffers live, so they need no clear
  always_comb
  begin
    flags_view = st_r.flags & core_flags_pkg::FLAGS_WR_MASK;
    flags_view[core_flags_pkg::BIT_SERIAL_RX] = serial_rx_full_in;
    flags_view[core_flags_pkg::BIT_SERIAL_TX] = serial_tx_empty_in;
  end

  // Unused cause bits forced low on read
  always_comb
  begin
    cause_view = 8'h00;
    cause_view[core_flags_pkg::BIT_OSC_SPEED] = st_r.osc_speed;
    cause_view[core_flags_pkg::BIT_POWER_ON]  = st_r.power_on;
    cause_view[core_flags_pkg::BIT_BROWNOUT]  = st_r.brownout;
  end

  assign any_reset    = soft_reset_in || brownout_reset_in;
  assign pc_low_write = wr_lane0 && wr_idx == core_flags_pkg::IDX_PC_LOW;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Priority: reset, pop, call, jump, vectoring, low byte write, step
  always_comb
  begin
    st_nxt = st_r;
    // Write response retires on bready
    if (st_r.bvalid && s_axi_bready_in)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready_in)
    begin
      st_nxt.rvalid = 1'b0;
    end
    // Software writes; a write landing with an event keeps the event
    if (wr_take)
    begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = core_flags_pkg::RESP_OKAY;
      if (!wr_aligned)
      begin
        st_nxt.bresp = core_flags_pkg::RESP_SLVERR;
      end
      else
      begin
        unique case (wr_idx)
          core_flags_pkg::IDX_PC_LOW,
          core_flags_pkg::IDX_PC_LATCH,
          core_flags_pkg::IDX_EVENT_FLAGS,
          core_flags_pkg::IDX_EVENT_ENABLE,
          core_flags_pkg::IDX_RESET_CAUSE: st_nxt.bresp = core_flags_pkg::RESP_OKAY;
          default:                         st_nxt.bresp = core_flags_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (wr_lane0 && wr_idx == core_flags_pkg::IDX_EVENT_FLAGS)
    begin
      st_nxt.flags = wbyte & core_flags_pkg::FLAGS_WR_MASK;
    end
    st_nxt.flags = st_nxt.flags | flag_events;
    if (wr_lane0 && wr_idx == core_flags_pkg::IDX_EVENT_ENABLE)
    begin
      st_nxt.enables = wbyte & core_flags_pkg::ENABLE_MASK;
    end
    if (wr_lane0 && wr_idx == core_flags_pkg::IDX_PC_LATCH)
    begin
      st_nxt.latch = wbyte[4:0];
    end
    if (wr_lane0 && wr_idx == core_flags_pkg::IDX_RESET_CAUSE)
    begin
      st_nxt.osc_speed = wbyte[core_flags_pkg::BIT_OSC_SPEED];
      st_nxt.power_on  = wbyte[core_flags_pkg::BIT_POWER_ON];
      st_nxt.brownout  = wbyte[core_flags_pkg::BIT_BROWNOUT];
    end
    // Reads return registered data one cycle after the take
    if (rd_take)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = core_flags_pkg::RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      if (!rd_aligned)
      begin
        st_nxt.rresp = core_flags_pkg::RESP_SLVERR;
      end
      else
      begin
        unique case (rd_idx)
          core_flags_pkg::IDX_PC_LOW:       st_nxt.rdata[7:0] = st_r.pc[7:0];
          core_flags_pkg::IDX_PC_LATCH:     st_nxt.rdata[4:0] = st_r.latch;
          core_flags_pkg::IDX_EVENT_FLAGS:  st_nxt.rdata[7:0] = flags_view;
          core_flags_pkg::IDX_EVENT_ENABLE: st_nxt.rdata[7:0] = st_r.enables;
          core_flags_pkg::IDX_RESET_CAUSE:  st_nxt.rdata[7:0] = cause_view;
          default:                          st_nxt.rresp = core_flags_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Program counter and return stack; no overflow flag exists
    if (return_in)
    begin
      st_nxt.pc = st_r.stack[st_r.sp - 3'd1];
      st_nxt.sp = st_r.sp - 3'd1;
    end
    else if (call_in)
    begin
      st_nxt.stack[st_r.sp] = st_r.pc + 13'd1;
      st_nxt.sp = st_r.sp + 3'd1;
      st_nxt.pc = {st_r.latch[4:3], target_in};
    end
    else if (jump_in)
    begin
      st_nxt.pc = {st_r.latch[4:3], target_in};
    end
    else if (vector_in)
    begin
      // Interrupted instruction has not run, so its own address returns
      st_nxt.stack[st_r.sp] = st_r.pc;
      st_nxt.sp = st_r.sp + 3'd1;
      st_nxt.pc = core_flags_pkg::IRQ_VECTOR;
    end
    else if (pc_low_write)
    begin
      st_nxt.pc = {st_r.latch, wbyte};
    end
    else if (instr_step_in)
    begin
      st_nxt.pc = st_r.pc + 13'd1;
    end
    // Synchronous reset causes; power-on and brown-out bits kept apart
    if (any_reset)
    begin
      st_nxt.pc        = core_flags_pkg::PC_RST;
      st_nxt.sp        = core_flags_pkg::SP_RST;
      st_nxt.flags     = core_flags_pkg::FLAGS_RST;
      st_nxt.enables   = core_flags_pkg::ENABLE_RST;
      st_nxt.latch     = core_flags_pkg::LATCH_RST;
      st_nxt.osc_speed = core_flags_pkg::OSC_SPEED_RST;
    end
    if (brownout_reset_in)
    begin
      st_nxt.brownout = 1'b0;
    end
  end

  // ****************************************************************
  // State register; power-on reset is the asynchronous one
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r           <= '0;
      st_r.osc_speed <= core_flags_pkg::OSC_SPEED_RST;
      st_r.power_on  <= core_flags_pkg::POWER_ON_RST;
      st_r.brownout  <= core_flags_pkg::BROWNOUT_RST;
      st_r.pc        <= core_flags_pkg::PC_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Enables only gate the request, never the flags
  assign peripheral_irq_out    = |(flags_view & st_r.enables);
  assign pc_out                = st_r.pc;
  assign pc_high_latch_out     = st_r.latch;
  // Brown-out config input is left unused; the external resistor input picks which output shows the speed bit
  assign osc_fast_internal_out = st_r.osc_speed && !external_resistor_osc_in;
  assign osc_resistor_rate_out = st_r.osc_speed && external_resistor_osc_in;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_EEPROM_SET: assert property (
    eeprom_write_done_in && !any_reset |=> st_r.flags[core_flags_pkg::BIT_EEPROM_DONE])
    else $error("eeprom done flag not set");

  AST_OVF_HOLD: assert property (
    st_r.flags[0] && !any_reset &&
    !(wr_lane0 && wr_idx == core_flags_pkg::IDX_EVENT_FLAGS && !wbyte[0])
    |=> st_r.flags[0])
    else $error("overflow flag dropped without clear");

  AST_TX_READ: assert property (
    rd_take && rd_aligned && rd_idx == core_flags_pkg::IDX_EVENT_FLAGS
    |=> s_axi_rdata_out[4] == $past(serial_tx_empty_in))
    else $error("transmit flag read wrong");

  AST_CAUSE_ZERO: assert property (
    rd_take && rd_aligned && rd_idx == core_flags_pkg::IDX_RESET_CAUSE
    |=> s_axi_rdata_out[7:4] == 4'h0 && !s_axi_rdata_out[2])
    else $error("unused cause bits nonzero");

  AST_BROWNOUT_CLR: assert property (
    brownout_reset_in |=> !st_r.brownout && st_r.power_on == $past(st_r.power_on))
    else $error("brownout reset handling wrong");

  AST_PCL_LOAD: assert property (
    pc_low_write && !any_reset && !return_in && !call_in && !jump_in && !vector_in
    |=> pc_out == {$past(st_r.latch), $past(wbyte)})
    else $error("low byte write load wrong");

  AST_CALL_LOAD: assert property (
    call_in && !return_in && !any_reset
    |=> pc_out == {$past(st_r.latch[4:3]), $past(target_in)})
    else $error("call target wrong");

  AST_RESET_PC: assert property (
    any_reset |=> pc_out == 13'h0000)
    else $error("reset left program counter");

  AST_CALL_RETURN: assert property (
    (call_in && !return_in && !any_reset) ##1
    (return_in && !any_reset) |=> pc_out == $past(pc_out, 2) + 13'd1)
    else $error("return address wrong");

  AST_STACK_WRAP: assert property (
    st_r.sp == 3'd7 && call_in && !return_in && !any_reset |=> st_r.sp == 3'd0)
    else $error("stack pointer did not wrap");

  AST_IRQ_GATE: assert property (
    st_r.enables == 8'h00 |-> !peripheral_irq_out)
    else $error("interrupt without enable");

  AST_OSC_SLOW: assert property (
    wr_lane0 && wr_idx == core_flags_pkg::IDX_RESET_CAUSE && !wbyte[3] && !any_reset
    |=> !osc_fast_internal_out && !osc_resistor_rate_out)
    else $error("slow rate not selected");

  CVR_CALL_RETURN: cover property (call_in ##1 return_in);
  CVR_WRAP:        cover property (st_r.sp == 3'd7 && call_in);
  CVR_EEPROM:      cover property (eeprom_write_done_in ##1 st_r.flags[7]);
  CVR_PCL_WRITE:   cover property (pc_low_write);

endmodule

`default_nettype wire

// ---- hdl/core_flags_pkg.sv ----
package core_flags_pkg;

  // ****************************************************************
  // Register map: printed offsets are word indices, byte = index * 4
  // ****************************************************************
  localparam int          ADDR_W           = 10;
  localparam logic [7:0]  IDX_PC_LOW       = 8'h02;
  localparam logic [7:0]  IDX_PC_LATCH     = 8'h0A;
  localparam logic [7:0]  IDX_EVENT_FLAGS  = 8'h0C;
  localparam logic [7:0]  IDX_EVENT_ENABLE = 8'h8C;
  localparam logic [7:0]  IDX_RESET_CAUSE  = 8'h8E;

  // ****************************************************************
  // Field positions, event flag register
  // ****************************************************************
  localparam int BIT_EEPROM_DONE  = 7;
  localparam int BIT_COMPARATOR   = 6;
  localparam int BIT_SERIAL_RX    = 5;
  localparam int BIT_SERIAL_TX    = 4;
  localparam int BIT_CAPT_COMP    = 2;
  localparam int BIT_PERIOD_MATCH = 1;
  localparam int BIT_WIDE_OVF     = 0;
  // Bits that software may write (bit 3 unused, bits 5 and 4 follow peripherals)
  localparam logic [7:0] FLAGS_WR_MASK    = 8'hC7;
  localparam logic [7:0] ENABLE_MASK      = 8'hF7;

  // ****************************************************************
  // Field positions, reset cause and oscillator speed register
  // ****************************************************************
  localparam int          BIT_OSC_SPEED    = 3;
  localparam int          BIT_POWER_ON     = 1;
  localparam int          BIT_BROWNOUT     = 0;
  localparam logic [7:0]  CAUSE_READ_MASK  = 8'h0B;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0]  FLAGS_RST        = 8'h00;
  localparam logic [7:0]  ENABLE_RST       = 8'h00;
  localparam logic        OSC_SPEED_RST    = 1'b1;
  localparam logic        POWER_ON_RST     = 1'b0;
  localparam logic        BROWNOUT_RST     = 1'b0;
  localparam logic [4:0]  LATCH_RST        = 5'h00;
  localparam logic [12:0] PC_RST           = 13'h0000;
  localparam logic [2:0]  SP_RST           = 3'h0;

  // ****************************************************************
  // Core constants
  // ****************************************************************
  localparam int          PC_W             = 13;
  localparam int          STACK_DEPTH      = 8;
  localparam logic [12:0] IRQ_VECTOR       = 13'h0004;
  localparam logic [1:0]  CCP_CAPTURE      = 2'h0;
  localparam logic [1:0]  CCP_COMPARE      = 2'h1;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// ---- verif/core_flags_pc_stack_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module core_flags_pc_stack_tb_top;
  // ****************************************************************
  // Register addresses and bench state
  // ****************************************************************
  localparam logic [9:0] addr_pcl   = {core_flags_pkg::IDX_PC_LOW, 2'b00};
  localparam logic [9:0] addr_latch = {core_flags_pkg::IDX_PC_LATCH, 2'b00};
  localparam logic [9:0] addr_flags = {core_flags_pkg::IDX_EVENT_FLAGS, 2'b00};
  localparam logic [9:0] addr_en    = {core_flags_pkg::IDX_EVENT_ENABLE, 2'b00};
  localparam logic [9:0] addr_cause = {core_flags_pkg::IDX_RESET_CAUSE, 2'b00};
  localparam logic [1:0] ok         = core_flags_pkg::RESP_OKAY;
  localparam logic [1:0] err        = core_flags_pkg::RESP_SLVERR;
  logic        core_clk_in = 1'b0, rst_n_in = 1'b0, soft_rst = 1'b0, bo_rst = 1'b0;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, osc_fast, osc_res;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        ee = 1'b0, cmp = 1'b0, rx = 1'b0, tx = 1'b1, cap = 1'b0, per = 1'b0, ovf = 1'b0, resist = 1'b0;
  logic [1:0]  ccp_mode = 2'h0;
  logic        step = 1'b0, jmp = 1'b0, cal = 1'b0, ret = 1'b0, vec = 1'b0, cmpm = 1'b0;
  logic [10:0] tgt = 11'h000;
  logic [12:0] pc_out, stk [8], pc_m;
  logic [4:0]  latch_out, lat;
  logic [7:0]  b;
  int          miscompares = 0, checks_done = 0, sp = 0;
  logic [33:0] exp_q [$];
  logic [1:0]  bexp_q [$];
  string       name_q [$];

  core_flags_pc_stack dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .soft_reset_in(soft_rst),
    .brownout_reset_in(bo_rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .eeprom_write_done_in(ee), .comparator_change_in(cmp), .serial_rx_full_in(rx), .serial_tx_empty_in(tx),
    .ccp_mode_in(ccp_mode), .ccp_capture_in(cap), .ccp_compare_match_in(cmpm), .period_match_in(per),
    .wide_timer_overflow_in(ovf), .external_resistor_osc_in(resist), .brownout_enable_config_in(1'b1),
    .instr_step_in(step), .jump_in(jmp), .call_in(cal), .return_in(ret), .vector_in(vec), .target_in(tgt),
    .pc_out(pc_out), .pc_high_latch_out(latch_out), .peripheral_irq_out(irq),
    .osc_fast_internal_out(osc_fast), .osc_resistor_rate_out(osc_res));

  // Free running core clock, 100 ns period
  always #50 core_clk_in = ~core_clk_in;

  // ****************************************************************
  // Compare, close and bus tasks
  // ****************************************************************
  task automatic chk(string nm, logic [33:0] seen, logic [33:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [33:0] ok8(logic [7:0] v);
    return {ok, 24'h00_0000, v};
  endfunction

  // Address and data offered together, each released once its own ready is seen
  task automatic wr(logic [9:0] a, logic [7:0] d, logic [1:0] r);
    bit a_done;
    bit w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    bexp_q.push_back(r);
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_done && w_done))
    begin
      @(posedge core_clk_in);
      if (!a_done && awready)
      begin
        awvalid <= 1'b0;
        a_done = 1'b1;
      end
      if (!w_done && wready)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge core_clk_in); while (!bvalid);
    bready <= 1'b0;
  endtask

  // Expected read result noted before the request goes out
  task automatic rd(logic [9:0] a, logic [33:0] e, string nm);
    exp_q.push_back(e); name_q.push_back(nm);
    @(posedge core_clk_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge core_clk_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk_in); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Monitor: each completed read or write response retires the oldest note of its kind
  always @(posedge core_clk_in)
  begin
    if (rvalid && rready && exp_q.size() > 0) chk(name_q.pop_front(), {rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready && bexp_q.size() > 0)
      chk("bresp", {32'h0000_0000, bresp}, {32'h0000_0000, bexp_q.pop_front()});
  end

  // One-cycle event pulses, mask in flag bit positions; spare bit 3 drives compare match
  task automatic ev(logic [7:0] m);
    @(posedge core_clk_in);
    ee <= m[7]; cmp <= m[6]; cap <= m[2]; per <= m[1]; ovf <= m[0]; cmpm <= m[3];
    @(posedge core_clk_in);
    ee <= 1'b0; cmp <= 1'b0; cap <= 1'b0; per <= 1'b0; ovf <= 1'b0; cmpm <= 1'b0;
  endtask

  // Decoder strobe with a circular stack model mirrored alongside
  task automatic dec(int k, logic [10:0] t);
    @(posedge core_clk_in);
    tgt <= t; step <= (k == 0); jmp <= (k == 1); cal <= (k == 2); ret <= (k == 3); vec <= (k == 4);
    if (k == 2 || k == 4)
    begin
      stk[sp] = (k == 2) ? pc_m + 13'h0001 : pc_m;
      sp = (sp + 1) % 8;
    end
    if (k == 3)
    begin
      sp = (sp + 7) % 8;
      pc_m = stk[sp];
    end
    else pc_m = (k == 0) ? pc_m + 13'h0001 : (k == 4) ? core_flags_pkg::IRQ_VECTOR : {lat[4:3], t};
    @(posedge core_clk_in);
    step <= 1'b0; jmp <= 1'b0; cal <= 1'b0; ret <= 1'b0; vec <= 1'b0;
    #1 chk("pc", {21'h00_0000, pc_out}, {21'h00_0000, pc_m});
    chk("latch", {29'h0000_0000, latch_out}, {29'h0000_0000, lat});
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h022d));
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(addr_cause, ok8(8'h08), "cause_rst");
    rd(addr_flags, ok8(8'h10), "flags_rst");
    chk("osc_fast", {33'h0, osc_fast}, 34'h1);
    resist <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    chk("osc_res", {32'h0, osc_res, osc_fast}, 34'h2);
    resist <= 1'b0;
    wr(addr_cause, 8'hff, ok);
    rd(addr_cause, ok8(8'h0b), "cause_ones");
    wr(addr_cause, 8'h03, ok);
    rd(addr_cause, ok8(8'h03), "cause_slow");
    chk("osc_slow", {32'h0, osc_res, osc_fast}, 34'h0);
    @(posedge core_clk_in) soft_rst <= 1'b1;
    @(posedge core_clk_in) soft_rst <= 1'b0;
    rd(addr_cause, ok8(8'h0b), "cause_soft");
    @(posedge core_clk_in) bo_rst <= 1'b1;
    @(posedge core_clk_in) bo_rst <= 1'b0;
    rd(addr_cause, ok8(8'h0a), "cause_bo");
    ccp_mode <= core_flags_pkg::CCP_CAPTURE;
    ev(8'hc7);
    rd(addr_flags, ok8(8'hd7), "flags_set");
    chk("irq_off", {33'h0, irq}, 34'h0);
    tx <= 1'b0;
    rx <= 1'b1;
    // Stale flags cleared before any enable goes on
    wr(addr_flags, 8'h10, ok);
    rd(addr_flags, ok8(8'h20), "flags_clr");
    wr(addr_en, 8'h01, ok);
    chk("irq_clr", {33'h0, irq}, 34'h0);
    ev(8'h01);
    @(posedge core_clk_in);
    chk("irq_on", {33'h0, irq}, 34'h1);
    tx <= 1'b1;
    rx <= 1'b0;
    // Capture/compare flag only follows the event of the selected mode
    wr(addr_flags, 8'h00, ok);
    ccp_mode <= 2'h2;
    ev(8'h0c);
    ccp_mode <= core_flags_pkg::CCP_COMPARE;
    ev(8'h04);
    rd(addr_flags, ok8(8'h10), "ccp_ignored");
    ev(8'h08);
    rd(addr_flags, ok8(8'h14), "ccp_match");
    wr(10'h3fc, 8'h55, err);
    rd(10'h3fc, {err, 32'h0000_0000}, "unmapped");
    lat = 5'($urandom); b = 8'($urandom); pc_m = {lat, b};
    wr(addr_latch, {3'h0, lat}, ok);
    wr(addr_pcl, b, ok);
    chk("pc_load", {21'h00_0000, pc_out}, {21'h00_0000, pc_m});
    rd(addr_pcl, ok8(b), "pc_low");
    rd(addr_latch, ok8({3'h0, lat}), "latch");
    dec(0, 11'h000);
    dec(1, 11'($urandom));
    for (int i = 0; i < 10; i++) dec(2, 11'($urandom));
    dec(4, 11'h000);
    for (int i = 0; i < 11; i++) dec(3, 11'h000);
    // Call and return on back-to-back cycles
    @(posedge core_clk_in);
    cal <= 1'b1;
    @(posedge core_clk_in);
    cal <= 1'b0;
    ret <= 1'b1;
    @(posedge core_clk_in);
    ret <= 1'b0;
    pc_m = pc_m + 13'h0001;
    #1 chk("pc_call_ret", {21'h00_0000, pc_out}, {21'h00_0000, pc_m});
    @(posedge core_clk_in) soft_rst <= 1'b1;
    @(posedge core_clk_in) soft_rst <= 1'b0;
    #1 chk("pc_reset", {21'h00_0000, pc_out}, 34'h0);
    end_sim();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    end_sim();
  end
endmodule

`default_nettype wire
